/* File: rtl/tfc_pkg.sv */
/*
  Shared constants for the transmit FIFO threshold control block:
  register map, field layout, reset values and state encodings.
  Assumes a 32-bit APB slave and 32-bit transmit data words.
*/
package tfc_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int unsigned APB_AW          = 8;
  localparam logic [7:0]  TX_CFG_OFS      = 8'h24;
  localparam logic [7:0]  RX_DESC_PTR_OFS = 8'h30;
  localparam logic [7:0]  TX_STATUS_OFS   = 8'h3C;

  // ****************************************
  // tx_configuration fields
  // ****************************************
  localparam int unsigned BURST_LSB = 20;
  localparam int unsigned BURST_W   = 3;
  localparam int unsigned FILL_LSB  = 8;
  localparam int unsigned FILL_W    = 6;
  localparam int unsigned DRAIN_LSB = 0;
  localparam int unsigned DRAIN_W   = 6;
  localparam logic [31:0] TX_CFG_MASK = 32'h0070_3F3F;

  // ****************************************
  // reset values
  // ****************************************
  // burst 8 words, fill 32 bytes, drain 32 bytes: never zero thresholds
  localparam logic [31:0] TX_CFG_RST      = 32'h0040_0101;
  localparam logic [31:0] RX_DESC_PTR_RST = 32'h0000_0000;
  localparam logic [31:0] RX_DESC_MASK    = 32'hFFFF_FFFC;

  // ****************************************
  // tx_status fields
  // ****************************************
  localparam int unsigned STAT_LEVEL_LSB = 0;
  localparam int unsigned STAT_PKTS_LSB  = 8;
  localparam int unsigned STAT_REQ_BIT   = 16;
  localparam int unsigned STAT_SEND_BIT  = 17;
  localparam int unsigned STAT_FILL_BIT  = 18;
  localparam int unsigned STAT_DRAIN_BIT = 19;

  // ****************************************
  // sizes and units
  // ****************************************
  localparam int unsigned UNIT_SHIFT   = 5;   // 32-byte threshold unit
  localparam int unsigned WORD_SHIFT   = 2;   // 4 bytes per word
  localparam int unsigned BYTE_W       = 16;
  localparam logic [2:0]  BURST_MAX_CODE = 3'h0;
  localparam logic [7:0]  BURST_MAX_WORDS = 8'h80;
  localparam logic [7:0]  BURST_ONE_WORD  = 8'h01;

  // ****************************************
  // state machines
  // ****************************************
  typedef enum logic [1:0]
  {
    DMA_IDLE  = 2'b00,
    DMA_REQ   = 2'b01,
    DMA_BURST = 2'b11
  } tfc_dma_state_t;

  typedef enum logic [0:0]
  {
    MAC_IDLE = 1'b0,
    MAC_SEND = 1'b1
  } tfc_mac_state_t;

endpackage

/* File: rtl/tfc_burst_dec.sv */
/*
  Decoder from the three-bit burst code to a word count.
  Purely combinational; the caller registers whatever it needs.
*/
`timescale 1ns/1ps
module tfc_burst_dec
  import tfc_pkg::*;
(
  // code in
  input  wire logic [2:0] i_code,
  // word count out
  output logic      [7:0] o_words
);

  // ****************************************
  // decode
  // ****************************************
  always_comb
  begin
    if (i_code == BURST_MAX_CODE)
    begin
      o_words = BURST_MAX_WORDS;
    end
    else
    begin
      o_words = BURST_ONE_WORD << (i_code - 3'h1);
    end
  end

endmodule

/* File: rtl/tfc_fifo.sv */
/*
  Flip-flop FIFO with valid/ready on both sides and a synchronous flush.
  Assumes one clock; DEPTH is a power of two.
*/
`timescale 1ns/1ps
module tfc_fifo #(
  parameter int unsigned W     = 33,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = $clog2(DEPTH),
  parameter int unsigned CW    = $clog2(DEPTH + 1)
)
(
  // clock and reset
  input  wire logic          i_sys_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_flush,
  // fill side
  input  wire logic [W-1:0]  i_in_data,
  input  wire logic          i_in_valid,
  output logic               o_in_ready,
  // drain side
  output logic      [W-1:0]  o_out_data,
  output logic               o_out_valid,
  input  wire logic          i_out_ready,
  // level
  output logic      [CW-1:0] o_count
);

  // ****************************************
  // storage and pointers
  // ****************************************
  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] wr_ptr_nxt;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] rd_ptr_nxt;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic          push;
  logic          pop;

  assign o_in_ready  = (count_r != CW'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem_r[rd_ptr_r];
  assign o_count     = count_r;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb
  begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (i_flush)
    begin
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
      count_nxt  = '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_nxt = wr_ptr_r + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_nxt = rd_ptr_r + AW'(1);
      end
      if (push && !pop)
      begin
        count_nxt = count_r + CW'(1);
      end
      else if (pop && !push)
      begin
        count_nxt = count_r - CW'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // data words carry no reset: only valid entries are ever read
  always_ff @(posedge i_sys_clk)
  begin
    if (push && !i_flush)
    begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

endmodule

/* File: rtl/tfc_ctrl.sv */
/*
  Transmit FIFO threshold control: APB register slave, DMA burst
  requester limited by burst code and fill threshold, and MAC start
  logic driven by drain threshold or a complete buffered packet.
  Assumes the bus-side DMA engine and MAC share i_sys_clk; software
  keeps the programming restrictions.
*/
// The APB slave port was left to the implementer.

`timescale 1ns/1ps
module tfc_ctrl
  import tfc_pkg::*;
#(
  parameter int unsigned TX_BUF_WORDS = 16
)
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_soft_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // bus master dma side
  input  wire logic        i_frag_pending,
  output logic             o_bus_req,
  input  wire logic        i_bus_gnt,
  output logic      [7:0]  o_burst_words,
  input  wire logic [31:0] i_dma_data,
  input  wire logic        i_dma_valid,
  input  wire logic        i_dma_last,
  input  wire logic        i_dma_eop,
  output logic             o_dma_ready,
  output logic             o_burst_done,
  // mac transmit side
  output logic      [31:0] o_mac_data,
  output logic             o_mac_eop,
  output logic             o_mac_valid,
  input  wire logic        i_mac_ready,
  output logic             o_mac_sending
);

  localparam int unsigned CW = $clog2(TX_BUF_WORDS + 1);

  // ****************************************
  // registers
  // ****************************************
  logic [31:0]    tx_cfg_r;
  logic [31:0]    tx_cfg_nxt;
  logic [31:0]    rx_desc_ptr_r;
  logic [31:0]    rx_desc_ptr_nxt;
  logic [31:0]    prdata_r;
  logic [31:0]    prdata_nxt;
  logic           addr_hit;
  logic           apb_wr;
  logic [31:0]    status_word;
  logic [2:0]     max_burst_code;
  logic [5:0]     fill_threshold;
  logic [5:0]     drain_threshold;

  assign max_burst_code  = tx_cfg_r[BURST_LSB +: BURST_W];
  assign fill_threshold  = tx_cfg_r[FILL_LSB +: FILL_W];
  assign drain_threshold = tx_cfg_r[DRAIN_LSB +: DRAIN_W];

  assign addr_hit  = (i_paddr == TX_CFG_OFS) || (i_paddr == RX_DESC_PTR_OFS)
                     || (i_paddr == TX_STATUS_OFS);
  assign apb_wr    = i_psel && i_penable && i_pwrite && addr_hit;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_hit;
  assign o_prdata  = prdata_r;

  always_comb
  begin
    tx_cfg_nxt      = tx_cfg_r;
    rx_desc_ptr_nxt = rx_desc_ptr_r;
    prdata_nxt      = prdata_r;
    if (i_soft_rst)
    begin
      tx_cfg_nxt      = TX_CFG_RST;
      rx_desc_ptr_nxt = RX_DESC_PTR_RST;
    end
    else if (apb_wr)
    begin
      if (i_paddr == TX_CFG_OFS)
      begin
        tx_cfg_nxt = i_pwdata & TX_CFG_MASK;
      end
      if (i_paddr == RX_DESC_PTR_OFS)
      begin
        rx_desc_ptr_nxt = i_pwdata & RX_DESC_MASK;
      end
    end
    // read data captured in the setup cycle, so it comes from flops
    if (i_psel && !i_penable)
    begin
      unique case (i_paddr)
        TX_CFG_OFS:      prdata_nxt = tx_cfg_r;
        RX_DESC_PTR_OFS: prdata_nxt = rx_desc_ptr_r;
        TX_STATUS_OFS:   prdata_nxt = status_word;
        default:         prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_cfg_r      <= TX_CFG_RST;
      rx_desc_ptr_r <= RX_DESC_PTR_RST;
      prdata_r      <= 32'h0000_0000;
    end
    else
    begin
      tx_cfg_r      <= tx_cfg_nxt;
      rx_desc_ptr_r <= rx_desc_ptr_nxt;
      prdata_r      <= prdata_nxt;
    end
  end

  // ****************************************
  // fifo and threshold compare
  // ****************************************
  logic [32:0]       fifo_out;
  logic              fifo_out_valid;
  logic              fifo_in_ready;
  logic              fifo_pop;
  logic              fifo_push;
  logic [CW-1:0]     fifo_count;
  logic [BYTE_W-1:0] used_bytes;
  logic [BYTE_W-1:0] free_bytes;
  logic              fill_ok;
  logic              drain_ok;
  logic              dma_acc;

  tfc_fifo #(
    .W     (33),
    .DEPTH (TX_BUF_WORDS)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_flush     (i_soft_rst),
    .i_in_data   ({i_dma_eop, i_dma_data}),
    .i_in_valid  (fifo_push),
    .o_in_ready  (fifo_in_ready),
    .o_out_data  (fifo_out),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_pop),
    .o_count     (fifo_count)
  );

  // byte figures; low five bits dropped to compare whole 32-byte units
  assign used_bytes = BYTE_W'(fifo_count) << WORD_SHIFT;
  assign free_bytes = BYTE_W'(TX_BUF_WORDS - 32'(fifo_count)) << WORD_SHIFT;
  assign fill_ok    = (free_bytes >> UNIT_SHIFT) >= BYTE_W'(fill_threshold);
  assign drain_ok   = (used_bytes >> UNIT_SHIFT) >= BYTE_W'(drain_threshold);

  // ****************************************
  // dma burst requester
  // ****************************************
  tfc_dma_state_t dma_state_r;
  tfc_dma_state_t dma_state_nxt;
  logic [7:0]     burst_cnt_r;
  logic [7:0]     burst_cnt_nxt;
  logic [7:0]     burst_words_r;
  logic [7:0]     burst_words_nxt;
  logic [7:0]     burst_limit;
  logic           burst_end;

  tfc_burst_dec u_burst_dec (
    .i_code  (max_burst_code),
    .o_words (burst_limit)
  );

  // fifo back-pressure stalls the dma word stream
  assign o_dma_ready   = (dma_state_r == DMA_BURST) && fifo_in_ready;
  assign fifo_push     = (dma_state_r == DMA_BURST) && i_dma_valid;
  assign dma_acc       = fifo_push && fifo_in_ready;
  assign o_bus_req     = (dma_state_r == DMA_REQ);
  assign o_burst_words = burst_words_r;
  assign burst_end     = dma_acc && (i_dma_last || (burst_cnt_r + 8'h01 == burst_words_r));
  assign o_burst_done  = burst_end;

  always_comb
  begin
    dma_state_nxt   = dma_state_r;
    burst_cnt_nxt   = burst_cnt_r;
    burst_words_nxt = burst_words_r;
    unique case (dma_state_r)
      DMA_IDLE:
      begin
        if (i_frag_pending && fill_ok)
        begin
          dma_state_nxt   = DMA_REQ;
          burst_words_nxt = burst_limit;
        end
      end
      DMA_REQ:
      begin
        if (i_bus_gnt)
        begin
          dma_state_nxt = DMA_BURST;
          burst_cnt_nxt = 8'h00;
        end
      end
      DMA_BURST:
      begin
        if (burst_end)
        begin
          dma_state_nxt = DMA_IDLE;
        end
        else if (dma_acc)
        begin
          burst_cnt_nxt = burst_cnt_r + 8'h01;
        end
      end
      default:
      begin
        dma_state_nxt = DMA_IDLE;
      end
    endcase
    if (i_soft_rst)
    begin
      dma_state_nxt = DMA_IDLE;
      burst_cnt_nxt = 8'h00;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dma_state_r   <= DMA_IDLE;
      burst_cnt_r   <= 8'h00;
      burst_words_r <= 8'h00;
    end
    else
    begin
      dma_state_r   <= dma_state_nxt;
      burst_cnt_r   <= burst_cnt_nxt;
      burst_words_r <= burst_words_nxt;
    end
  end

  // ****************************************
  // mac start and packet count
  // ****************************************
  tfc_mac_state_t mac_state_r;
  tfc_mac_state_t mac_state_nxt;
  logic [7:0]     pkt_cnt_r;
  logic [7:0]     pkt_cnt_nxt;
  logic           pkt_in;
  logic           pkt_out;

  assign o_mac_valid   = (mac_state_r == MAC_SEND) && fifo_out_valid;
  assign fifo_pop      = (mac_state_r == MAC_SEND) && i_mac_ready;
  assign o_mac_data    = fifo_out[31:0];
  assign o_mac_eop     = fifo_out[32];
  assign o_mac_sending = (mac_state_r == MAC_SEND);
  assign pkt_in        = dma_acc && i_dma_eop;
  assign pkt_out       = o_mac_valid && i_mac_ready && fifo_out[32];

  always_comb
  begin
    mac_state_nxt = mac_state_r;
    pkt_cnt_nxt   = pkt_cnt_r;
    // both ends may move in one cycle; net change keeps the count exact
    if (pkt_in && !pkt_out)
    begin
      pkt_cnt_nxt = pkt_cnt_r + 8'h01;
    end
    else if (pkt_out && !pkt_in)
    begin
      pkt_cnt_nxt = pkt_cnt_r - 8'h01;
    end
    unique case (mac_state_r)
      MAC_IDLE:
      begin
        if (drain_ok || (pkt_cnt_r != 8'h00))
        begin
          mac_state_nxt = MAC_SEND;
        end
      end
      MAC_SEND:
      begin
        if (pkt_out)
        begin
          mac_state_nxt = MAC_IDLE;
        end
      end
    endcase
    if (i_soft_rst)
    begin
      mac_state_nxt = MAC_IDLE;
      pkt_cnt_nxt   = 8'h00;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mac_state_r <= MAC_IDLE;
      pkt_cnt_r   <= 8'h00;
    end
    else
    begin
      mac_state_r <= mac_state_nxt;
      pkt_cnt_r   <= pkt_cnt_nxt;
    end
  end

  // ****************************************
  // status word
  // ****************************************
  always_comb
  begin
    status_word                           = 32'h0000_0000;
    status_word[STAT_LEVEL_LSB +: 8]      = 8'(fifo_count);
    status_word[STAT_PKTS_LSB +: 8]       = pkt_cnt_r;
    status_word[STAT_REQ_BIT]             = o_bus_req;
    status_word[STAT_SEND_BIT]            = o_mac_sending;
    status_word[STAT_FILL_BIT]            = fill_ok;
    status_word[STAT_DRAIN_BIT]           = drain_ok;
  end

endmodule

/* File: verif/tfc_ctrl_sva.sv */
/*
  Checker for tfc_ctrl, watching only its ports.
  Assumes one clock domain and the async active-low reset.
*/
`timescale 1ns/1ps
module tfc_ctrl_chk
  import tfc_pkg::*;
#(
  parameter int unsigned TX_BUF_WORDS = 16
)
(
  // clock, reset, apb
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic        i_soft_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // dma and mac
  input wire logic        i_frag_pending,
  input wire logic        o_bus_req,
  input wire logic        i_bus_gnt,
  input wire logic [7:0]  o_burst_words,
  input wire logic        i_dma_valid,
  input wire logic        i_dma_last,
  input wire logic        o_dma_ready,
  input wire logic        o_burst_done,
  input wire logic [31:0] o_mac_data,
  input wire logic        o_mac_eop,
  input wire logic        o_mac_valid,
  input wire logic        i_mac_ready,
  input wire logic        o_mac_sending
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // ****************************************
  // beats taken in the current burst
  // ****************************************
  logic [7:0] beat_r;
  logic [7:0] beat_nxt;
  always_comb
  begin
    beat_nxt = beat_r;
    if (i_dma_valid && o_dma_ready)
      beat_nxt = o_burst_done ? 8'h00 : beat_r + 8'h01;
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      beat_r <= 8'h00;
    else
      beat_r <= beat_nxt;
  end
  sequence s_beat;
    i_dma_valid && o_dma_ready;
  endsequence
  sequence s_pop_eop;
    o_mac_valid && i_mac_ready && o_mac_eop;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  chk_burst_cap: assert property (s_beat |-> beat_r < o_burst_words)
    else $error("burst longer than its limit");
  chk_burst_end: assert property (s_beat ##0 (beat_r + 8'h01 == o_burst_words)
    |-> o_burst_done)
    else $error("burst not ended at its limit");
  chk_last_ends: assert property (s_beat ##0 i_dma_last |-> o_burst_done)
    else $error("last word did not end burst");
  chk_done_drops: assert property (o_burst_done |-> s_beat ##1 !o_dma_ready)
    else $error("ready stayed after burst end");
  chk_req_cause: assert property ($rose(o_bus_req) |-> $past(i_frag_pending))
    else $error("bus request without pending fragment");
  chk_req_hold: assert property (o_bus_req && !i_bus_gnt && !i_soft_rst |=> o_bus_req)
    else $error("bus request dropped before grant");
  chk_mac_start: assert property ($rose(o_mac_sending) |-> o_mac_valid)
    else $error("mac started on an empty buffer");
  chk_mac_stop: assert property (s_pop_eop |=> !o_mac_sending)
    else $error("mac still sending after packet end");
  chk_mac_hold: assert property (o_mac_valid && !i_mac_ready && !i_soft_rst
    |=> o_mac_valid && $stable(o_mac_data) && $stable(o_mac_eop))
    else $error("mac word changed while stalled");
  chk_apb_err: assert property (o_pslverr |-> i_psel && i_penable && o_pready)
    else $error("slave error outside access phase");
endmodule
bind tfc_ctrl tfc_ctrl_chk #(.TX_BUF_WORDS(TX_BUF_WORDS)) u_chk (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .i_soft_rst(i_soft_rst), .i_psel(i_psel), .i_penable(i_penable),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_frag_pending(i_frag_pending),
  .o_bus_req(o_bus_req), .i_bus_gnt(i_bus_gnt), .o_burst_words(o_burst_words),
  .i_dma_valid(i_dma_valid), .i_dma_last(i_dma_last), .o_dma_ready(o_dma_ready),
  .o_burst_done(o_burst_done), .o_mac_data(o_mac_data), .o_mac_eop(o_mac_eop),
  .o_mac_valid(o_mac_valid), .i_mac_ready(i_mac_ready), .o_mac_sending(o_mac_sending));

/* File: verif/tfc_host_mem.sv */
/*
  Host memory model behind the bus master: grants and feeds one
  packet fragment per load. Assumes the tfc_ctrl dma handshake.
*/
`timescale 1ns/1ps
module tfc_host_mem
(
  // bench control
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_load,
  input  wire logic [7:0]  i_len,
  input  wire logic        i_slow,
  // dma side
  input  wire logic        i_bus_req,
  input  wire logic        i_dma_ready,
  input  wire logic        i_burst_done,
  output logic             o_frag_pending,
  output logic             o_bus_gnt,
  output logic      [31:0] o_dma_data,
  output logic             o_dma_valid,
  output logic             o_dma_last,
  output logic             o_dma_eop,
  output logic      [7:0]  o_beats,
  output logic      [7:0]  o_left
);
  logic [7:0]  left_r, left_nxt, beats_r, beats_nxt;
  logic [1:0]  dly_r, dly_nxt;
  logic        own_r, own_nxt, take;
  logic [31:0] seq_r, seq_nxt;
  assign o_frag_pending = (left_r != 8'h00);
  assign o_dma_valid    = own_r && o_frag_pending;
  assign o_dma_last     = (left_r == 8'h01);
  assign o_dma_eop      = o_dma_last;
  // idle bus shows inverted data so a stale word is never mistaken
  assign o_dma_data     = o_dma_valid ? seq_r : ~seq_r;
  // slow mode keeps the requester waiting three cycles
  assign o_bus_gnt      = i_bus_req && !own_r && (dly_r >= (i_slow ? 2'h3 : 2'h0));
  assign take           = o_dma_valid && i_dma_ready;
  assign o_beats        = beats_r;
  assign o_left         = left_r;
  always_comb
  begin
    left_nxt  = left_r;
    beats_nxt = beats_r;
    own_nxt   = own_r;
    seq_nxt   = seq_r;
    dly_nxt   = (i_bus_req && !own_r && dly_r != 2'h3) ? dly_r + 2'h1 : dly_r;
    if (i_load && !o_frag_pending)
      left_nxt = i_len;
    if (o_bus_gnt)
    begin
      own_nxt = 1'b1;
      dly_nxt = 2'h0;
    end
    if (take)
    begin
      left_nxt  = left_r - 8'h01;
      seq_nxt   = seq_r + 32'h0000_0001;
      beats_nxt = i_burst_done ? 8'h00 : beats_r + 8'h01;
      own_nxt   = !i_burst_done;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      left_r  <= 8'h00;
      beats_r <= 8'h00;
      dly_r   <= 2'h0;
      own_r   <= 1'b0;
      seq_r   <= 32'hA500_0000;
    end
    else
    begin
      left_r  <= left_nxt;
      beats_r <= beats_nxt;
      dly_r   <= dly_nxt;
      own_r   <= own_nxt;
      seq_r   <= seq_nxt;
    end
  end
endmodule

/* File: verif/testbench.sv */
/*
  Self-checking bench for tfc_ctrl with a host memory model.
  Assumes 200 MHz clock and zero-wait apb answers.
*/
`timescale 1ns/1ps
module testbench
  import tfc_pkg::*;
;
  logic        clk, rst_n, soft_rst, psel, penable, pwrite, mac_ready, h_load, h_slow, err;
  logic [7:0]  paddr, h_len;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata, dma_data, mac_data;
  wire  [7:0]  burst_words, h_beats, h_left;
  wire         pready, pslverr, frag_pending, bus_req, bus_gnt, dma_valid, dma_last;
  wire         dma_eop, dma_ready, burst_done, mac_eop, mac_valid, mac_sending;
  int          fail_count, tests_run;
  tfc_ctrl #(.TX_BUF_WORDS(16)) u_dut (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_soft_rst(soft_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_frag_pending(frag_pending), .o_bus_req(bus_req),
    .i_bus_gnt(bus_gnt), .o_burst_words(burst_words), .i_dma_data(dma_data),
    .i_dma_valid(dma_valid), .i_dma_last(dma_last), .i_dma_eop(dma_eop),
    .o_dma_ready(dma_ready), .o_burst_done(burst_done), .o_mac_data(mac_data),
    .o_mac_eop(mac_eop), .o_mac_valid(mac_valid), .i_mac_ready(mac_ready),
    .o_mac_sending(mac_sending));
  tfc_host_mem u_host (.i_sys_clk(clk), .i_rst_n(rst_n), .i_load(h_load), .i_len(h_len),
    .i_slow(h_slow), .i_bus_req(bus_req), .i_dma_ready(dma_ready),
    .i_burst_done(burst_done), .o_frag_pending(frag_pending), .o_bus_gnt(bus_gnt),
    .o_dma_data(dma_data), .o_dma_valid(dma_valid), .o_dma_last(dma_last),
    .o_dma_eop(dma_eop), .o_beats(h_beats), .o_left(h_left));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("mismatch at %0t ns: %s", $time, msg);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] cfg(logic [2:0] c, logic [5:0] f, logic [5:0] d);
    return {9'h000, c, 6'h00, f, 2'h0, d};
  endfunction
  task load(input logic [7:0] len);
    @(posedge clk);
    h_load <= 1'b1;
    h_len <= len;
    @(posedge clk);
    h_load <= 1'b0;
  endtask
  task wait_idle;
    int n;
    n = 0;
    while ((h_left !== 8'h00 || mac_sending !== 1'b0 || bus_req !== 1'b0) && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    check(n < 3000, "traffic did not drain");
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_regs;
    apb(1'b0, TX_CFG_OFS, 32'h0); check(rd === TX_CFG_RST, "config reset");
    apb(1'b1, TX_CFG_OFS, 32'hFFFF_E1C1);
    apb(1'b0, TX_CFG_OFS, 32'h0);
    check(rd === (32'hFFFF_E1C1 & TX_CFG_MASK), "config fields");
    apb(1'b0, RX_DESC_PTR_OFS, 32'h0); check(rd === RX_DESC_PTR_RST, "pointer reset");
    apb(1'b1, RX_DESC_PTR_OFS, 32'hFFFF_FFFC);
    apb(1'b0, RX_DESC_PTR_OFS, 32'h0); check(rd === RX_DESC_MASK, "pointer align");
    apb(1'b0, 8'h10, 32'h0); check(err === 1'b1 && rd === 32'h0, "unmapped read");
    @(posedge clk) soft_rst <= 1'b1;
    @(posedge clk) soft_rst <= 1'b0;
    apb(1'b0, TX_CFG_OFS, 32'h0); check(rd === TX_CFG_RST, "soft reset config");
  endtask
  task t_burst;
    int n;
    logic [7:0] exp;
    for (int c = 0; c < 8; c++)
    begin
      exp = (c == 0) ? 8'h80 : 8'h01 << (c - 1);
      apb(1'b1, TX_CFG_OFS, cfg(c[2:0], 6'h01, 6'h01));
      load(8'h82);
      n = 0;
      while (burst_done !== 1'b1 && n < 500)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      check(burst_words === exp && h_beats + 8'h01 === exp, "burst length");
      wait_idle;
    end
  endtask
  task t_fill;
    mac_ready <= 1'b0;
    apb(1'b1, TX_CFG_OFS, cfg(3'h1, 6'h02, 6'h02));
    load(8'h14);
    repeat (40) @(posedge clk);
    apb(1'b0, TX_STATUS_OFS, 32'h0);
    check(rd[7:0] === 8'h01 && rd[16] === 1'b0 && rd[18] === 1'b0, "fill two units");
    apb(1'b1, TX_CFG_OFS, cfg(3'h1, 6'h01, 6'h02));
    repeat (60) @(posedge clk);
    apb(1'b0, TX_STATUS_OFS, 32'h0);
    check(rd[7:0] === 8'h09 && mac_sending === 1'b0, "fill one unit");
    apb(1'b1, TX_CFG_OFS, cfg(3'h1, 6'h01, 6'h01));
    repeat (3) @(posedge clk);
    check(mac_sending === 1'b1 && mac_valid === 1'b1, "drain start");
    mac_ready <= 1'b1;
    wait_idle;
  endtask
  task t_eop;
    int n, k;
    mac_ready <= 1'b0;
    h_slow <= 1'b1;
    apb(1'b1, TX_CFG_OFS, cfg(3'h4, 6'h01, 6'h02));
    load(8'h03);
    repeat (20) @(posedge clk);
    check(mac_sending === 1'b1 && bus_req === 1'b0, "whole packet start");
    mac_ready <= 1'b1;
    n = 0;
    k = 0;
    while (n < 20)
    begin
      @(posedge clk);
      n++;
      if (mac_valid === 1'b1)
      begin
        k++;
        if (k > 1)
          check(mac_data === rd + 32'h0000_0001, "packet word order");
        rd = mac_data;
      end
      if (mac_valid === 1'b1 && mac_eop === 1'b1)
        break;
    end
    check(k == 3, "packet words at mac");
    h_slow <= 1'b0;
    wait_idle;
  endtask
  initial
  begin
    #100000;
    fail_count++;
    $display("mismatch at %0t ns: watchdog expired", $time);
    final_report;
  end
  initial
  begin
    rst_n = 1'b0; soft_rst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; mac_ready = 1'b1; h_load = 1'b0; h_slow = 1'b0;
    h_len = 8'h00; fail_count = 0; tests_run = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_burst;
    t_fill;
    t_eop;
    final_report;
  end
endmodule
